// ==== logic/hbfs_consts.vh ====
// Register map, field positions, reset values and delay figures of the bridge fault supervisor.
`ifndef HBFS_CONSTS_VH
`define HBFS_CONSTS_VH

// Register word offsets (byte addresses on the bus).
`define HBFS_ADDR_CONFIG     4'h0
`define HBFS_ADDR_STATUS_CONTROL_REG    4'h4
`define HBFS_ADDR_DIAG1      4'h8
`define HBFS_ADDR_STATE      4'hC

// Configuration register fields.
`define HBFS_CFG_OLA_BIT     0
`define HBFS_CFG_RESET       8'h00

// Status and control register fields.
`define HBFS_SC_LATCH_BIT    0
`define HBFS_SC_TESTA_BIT    1
`define HBFS_SC_TESTB_BIT    2
`define HBFS_SC_STATUS_BIT   3
`define HBFS_SC_RESET        8'h00

// Diagnosis register one fields.
`define HBFS_D1_SCB_BIT      0
`define HBFS_D1_SCG_BIT      1
`define HBFS_D1_SCL_BIT      2
`define HBFS_D1_OL_BIT       3
`define HBFS_D1_RESET        8'h00

// Delay figures in nanoseconds and the clock period.
`define HBFS_CLK_NS          10
`define HBFS_RETEST_NS       20000
`define HBFS_SCL_RETEST_NS   20000
`define HBFS_OL_START_NS     100000
`define HBFS_OL_SETTLE_NS    200000
`define HBFS_OL_FILTER_NS    20000
`define HBFS_UV_FILTER_NS    10000
`define HBFS_MON_OFF_NS      10000
`define HBFS_MON_ON_NS       50000
`define HBFS_POR_NS          100000

`endif

// ==== logic/hbfs_supervisor.v ====
// Fault, open-load, supply monitor and power-on supervision of a bridge driver.
//
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "hbfs_consts.vh"

module hbfs_supervisor #(
    parameter RETEST_CYC  = ((`HBFS_RETEST_NS + `HBFS_CLK_NS - 1) / `HBFS_CLK_NS),
    parameter SCL_CYC     = ((`HBFS_SCL_RETEST_NS + `HBFS_CLK_NS - 1) / `HBFS_CLK_NS),
    parameter OL_START    = ((`HBFS_OL_START_NS + `HBFS_CLK_NS - 1) / `HBFS_CLK_NS),
    parameter OL_SETTLE   = ((`HBFS_OL_SETTLE_NS + `HBFS_CLK_NS - 1) / `HBFS_CLK_NS),
    parameter OL_FILTER   = ((`HBFS_OL_FILTER_NS + `HBFS_CLK_NS - 1) / `HBFS_CLK_NS),
    parameter UV_FILTER   = ((`HBFS_UV_FILTER_NS + `HBFS_CLK_NS - 1) / `HBFS_CLK_NS),
    parameter MON_OFF     = ((`HBFS_MON_OFF_NS + `HBFS_CLK_NS - 1) / `HBFS_CLK_NS),
    parameter MON_ON      = ((`HBFS_MON_ON_NS + `HBFS_CLK_NS - 1) / `HBFS_CLK_NS),
    parameter POR_CYC     = ((`HBFS_POR_NS + `HBFS_CLK_NS - 1) / `HBFS_CLK_NS)
) (
    // Clock and reset.
    input  wire        core_clk,
    input  wire        rst_n,
    // Avalon-MM register slave.
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // Supply indications.
    input  wire        por_active,
    input  wire        por_below_threshold,
    input  wire        supply_undervoltage,
    input  wire        logic_undervoltage,
    input  wire        logic_overvoltage,
    input  wire        test_upper_exceeded,
    input  wire        test_lower_exceeded,
    // Bridge fault and sense inputs.
    input  wire        short_to_battery,
    input  wire        short_to_ground,
    input  wire        high_side_off,
    input  wire        output_below_ground,
    input  wire        pullup_single,
    input  wire        pullup_double,
    input  wire        disable_input,
    // Shared open-drain enable/fault line.
    input  wire        enable_fault_line_in,
    output reg         enable_fault_line_out,
    output reg         enable_fault_line_oe_n,
    // Bridge control.
    output reg         bridge_enable,
    output reg         opposite_driver_off,
    output reg         retry_drivers_on,
    output reg         pulldown_enable
);

    ////////////////////////////////////////////////////////////////////////
    // Delay counter helpers.

    function [17:0] count_up;
        input        cond;
        input [17:0] cnt;
        input [17:0] limit;
        begin
            if (!cond) begin
                count_up = 18'h00000;
            end else if (cnt < limit) begin
                count_up = cnt + 18'h00001;
            end else begin
                count_up = cnt;
            end
        end
    endfunction

    localparam [17:0] RETEST_T = RETEST_CYC[17:0];
    localparam [17:0] SCL_T    = SCL_CYC[17:0];
    localparam [17:0] OLST_T   = OL_START[17:0];
    localparam [17:0] OLSE_T   = OL_SETTLE[17:0];
    localparam [17:0] OLFI_T   = OL_FILTER[17:0];
    localparam [17:0] UV_T     = UV_FILTER[17:0];
    localparam [17:0] OFF_T    = MON_OFF[17:0];
    localparam [17:0] ON_T     = MON_ON[17:0];
    localparam [17:0] POR_T    = POR_CYC[17:0];

    // Short fault sequence states.
    localparam [4:0] S_IDLE   = 5'h01;
    localparam [4:0] S_RETRY  = 5'h02;
    localparam [4:0] S_SCLW   = 5'h04;
    localparam [4:0] S_SCLCHK = 5'h08;
    localparam [4:0] S_HALT   = 5'h10;

    ////////////////////////////////////////////////////////////////////////
    // State.

    reg [7:0]  config_reg;
    reg [7:0]  status_control_reg;
    reg [7:0]  diagnosis_register_one;
    reg [4:0]  short_state_reg;
    reg        short_kind_reg;
    reg [17:0] short_cnt_reg;
    reg [17:0] por_cnt_reg;
    reg [17:0] uv_cnt_reg;
    reg [17:0] off_cnt_reg;
    reg [17:0] on_cnt_reg;
    reg [17:0] olst_cnt_reg;
    reg [17:0] olse_cnt_reg;
    reg [17:0] olfi_cnt_reg;
    reg [17:0] ola_cnt_reg;
    reg        mon_fault_reg;
    reg        ov_latched_reg;
    reg        halted_reg;
    reg        dis_prev_reg;
    reg        line_prev_reg;

    wire       running      = (por_cnt_reg == POR_T);
    wire       test_upper   = status_control_reg[`HBFS_SC_TESTA_BIT] & ~status_control_reg[`HBFS_SC_TESTB_BIT];
    wire       test_lower   = status_control_reg[`HBFS_SC_TESTB_BIT] & ~status_control_reg[`HBFS_SC_TESTA_BIT];
    wire       real_fault   = logic_undervoltage | logic_overvoltage;
    // Self-test shifts thresholds but real supply faults still act.
    wire       mon_raw      = real_fault | (test_upper & test_upper_exceeded)
                              | (test_lower & ~test_lower_exceeded);
    wire       disabled_now = disable_input | ~enable_fault_line_in;
    // A disable-then-enable sequence on either input restarts the device.
    wire       reenable     = (dis_prev_reg & ~disable_input) | (~line_prev_reg & enable_fault_line_in);
    wire       short_any    = short_to_battery | short_to_ground;
    wire       ola_armed    = config_reg[`HBFS_CFG_OLA_BIT] & running & ~disabled_now & ~halted_reg;
    wire       olst_done    = (olst_cnt_reg == OLST_T);
    wire       olse_done    = (olse_cnt_reg == OLSE_T);
    wire       olfi_done    = (olfi_cnt_reg == OLFI_T);
    wire       bus_hit      = (avs_read | avs_write) & avs_waitrequest;

    ////////////////////////////////////////////////////////////////////////
    // Power-on delay, supply filters and monitor latch.

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            por_cnt_reg    <= 18'h00000;
            uv_cnt_reg     <= 18'h00000;
            off_cnt_reg    <= 18'h00000;
            on_cnt_reg     <= 18'h00000;
            mon_fault_reg  <= 1'b0;
            ov_latched_reg <= 1'b0;
            dis_prev_reg   <= 1'b0;
            line_prev_reg  <= 1'b1;
        end else begin
            por_cnt_reg   <= count_up(~por_active, por_cnt_reg, POR_T);
            uv_cnt_reg    <= count_up(supply_undervoltage, uv_cnt_reg, UV_T);
            off_cnt_reg   <= count_up(mon_raw, off_cnt_reg, OFF_T);
            on_cnt_reg    <= count_up(~mon_raw, on_cnt_reg, ON_T);
            dis_prev_reg  <= disable_input;
            line_prev_reg <= enable_fault_line_in;
            if (por_active) begin
                mon_fault_reg  <= 1'b0;
                ov_latched_reg <= 1'b0;
            end else begin
                if (off_cnt_reg == OFF_T) begin
                    mon_fault_reg <= 1'b1;
                end else if (on_cnt_reg == ON_T && !ov_latched_reg) begin
                    mon_fault_reg <= 1'b0;
                end
                if (logic_overvoltage && status_control_reg[`HBFS_SC_LATCH_BIT]) begin
                    ov_latched_reg <= 1'b1;
                end else if (reenable) begin
                    ov_latched_reg <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Short, retry and overload retest sequence.

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            short_state_reg <= S_IDLE;
            short_kind_reg  <= 1'b0;
            short_cnt_reg   <= 18'h00000;
            halted_reg      <= 1'b0;
        end else if (por_active) begin
            short_state_reg <= S_IDLE;
            short_cnt_reg   <= 18'h00000;
            halted_reg      <= 1'b0;
        end else begin
            case (short_state_reg)
                S_IDLE: begin
                    short_cnt_reg <= 18'h00000;
                    if (short_any && running && !disabled_now && !halted_reg) begin
                        short_kind_reg  <= short_to_ground;
                        short_state_reg <= S_RETRY;
                    end
                end
                S_RETRY: begin
                    short_cnt_reg <= short_cnt_reg + 18'h00001;
                    if (short_cnt_reg == RETEST_T) begin
                        short_cnt_reg   <= 18'h00000;
                        // An unconfirmed short is disregarded.
                        short_state_reg <= short_any ? S_SCLW : S_IDLE;
                    end
                end
                S_SCLW: begin
                    short_cnt_reg <= short_cnt_reg + 18'h00001;
                    if (short_cnt_reg == SCL_T) begin
                        short_cnt_reg   <= 18'h00000;
                        short_state_reg <= S_SCLCHK;
                    end
                end
                S_SCLCHK: begin
                    short_cnt_reg <= short_cnt_reg + 18'h00001;
                    if (short_cnt_reg == RETEST_T) begin
                        halted_reg      <= 1'b1;
                        short_state_reg <= S_HALT;
                    end
                end
                S_HALT: begin
                    if (reenable) begin
                        halted_reg      <= 1'b0;
                        short_state_reg <= S_IDLE;
                    end
                end
                default: begin
                    short_state_reg <= S_IDLE;
                end
            endcase
            if (short_state_reg != S_HALT && halted_reg && reenable) begin
                halted_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Open-load timing: disabled-state chain and active-state check.

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            olst_cnt_reg <= 18'h00000;
            olse_cnt_reg <= 18'h00000;
            olfi_cnt_reg <= 18'h00000;
            ola_cnt_reg  <= 18'h00000;
        end else begin
            olst_cnt_reg <= count_up(disabled_now & running, olst_cnt_reg, OLST_T);
            olse_cnt_reg <= count_up(olst_done & disabled_now, olse_cnt_reg, OLSE_T);
            olfi_cnt_reg <= count_up(olse_done & disabled_now & pullup_single & ~pullup_double,
                                     olfi_cnt_reg, OLFI_T);
            ola_cnt_reg  <= count_up(ola_armed & high_side_off & ~output_below_ground,
                                     ola_cnt_reg, OLFI_T);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers and bus slave; one wait state per access.

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            config_reg             <= `HBFS_CFG_RESET;
            status_control_reg     <= `HBFS_SC_RESET;
            diagnosis_register_one <= `HBFS_D1_RESET;
            avs_readdata           <= 32'h00000000;
            avs_waitrequest        <= 1'b1;
        end else if (por_below_threshold) begin
            config_reg             <= `HBFS_CFG_RESET;
            status_control_reg     <= `HBFS_SC_RESET;
            diagnosis_register_one <= `HBFS_D1_RESET;
            avs_readdata           <= 32'h00000000;
            avs_waitrequest        <= 1'b1;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if (por_active) begin
                config_reg             <= `HBFS_CFG_RESET;
                status_control_reg     <= `HBFS_SC_RESET;
                diagnosis_register_one <= `HBFS_D1_RESET;
            end else begin
                if (bus_hit && avs_write && avs_byteenable[0]) begin
                    case (avs_address)
                        `HBFS_ADDR_CONFIG: begin
                            config_reg <= {7'h00, avs_writedata[`HBFS_CFG_OLA_BIT]};
                        end
                        `HBFS_ADDR_STATUS_CONTROL_REG: begin
                            status_control_reg[2:0] <= avs_writedata[2:0];
                        end
                        `HBFS_ADDR_DIAG1: begin
                            diagnosis_register_one <= diagnosis_register_one & ~avs_writedata[7:0];
                        end
                        default: begin
                        end
                    endcase
                end
                // Unfiltered monitor input; a selected test encoding sets the status only when its comparator input calls for it.
                status_control_reg[`HBFS_SC_STATUS_BIT] <= mon_raw;
                // Hardware sets win over software clears.
                if (short_state_reg == S_SCLCHK && short_cnt_reg == RETEST_T) begin
                    if (!short_any) begin
                        diagnosis_register_one[`HBFS_D1_SCL_BIT] <= 1'b1;
                    end else if (short_kind_reg) begin
                        diagnosis_register_one[`HBFS_D1_SCG_BIT] <= 1'b1;
                    end else begin
                        diagnosis_register_one[`HBFS_D1_SCB_BIT] <= 1'b1;
                    end
                end
                if ((olfi_done || ola_cnt_reg == OLFI_T) && !halted_reg) begin
                    diagnosis_register_one[`HBFS_D1_OL_BIT] <= 1'b1;
                end
            end
            if (bus_hit && avs_read) begin
                case (avs_address)
                    `HBFS_ADDR_CONFIG:  avs_readdata <= {24'h000000, config_reg};
                    `HBFS_ADDR_STATUS_CONTROL_REG: avs_readdata <= {24'h000000, status_control_reg};
                    `HBFS_ADDR_DIAG1:   avs_readdata <= {24'h000000, diagnosis_register_one};
                    `HBFS_ADDR_STATE:   avs_readdata <= {24'h000000, 1'b0, running, mon_fault_reg,
                                                         ov_latched_reg, halted_reg, short_state_reg[2:0]};
                    default:            avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enable/fault line and bridge outputs.

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_fault_line_out  <= 1'b0;
            enable_fault_line_oe_n <= 1'b1;
            bridge_enable          <= 1'b0;
            opposite_driver_off    <= 1'b0;
            retry_drivers_on       <= 1'b0;
            pulldown_enable        <= 1'b0;
        end else begin
            enable_fault_line_out <= 1'b0;
            if (por_below_threshold) begin
                enable_fault_line_oe_n <= 1'b1;
            end else begin
                enable_fault_line_oe_n <= ~(por_active | ~running | mon_fault_reg
                                            | ov_latched_reg | halted_reg);
            end
            bridge_enable <= running & ~por_active & enable_fault_line_in & ~disable_input
                             & ~mon_fault_reg & ~ov_latched_reg & ~halted_reg
                             & (uv_cnt_reg != UV_T);
            opposite_driver_off <= (short_state_reg == S_SCLCHK);
            retry_drivers_on    <= (short_state_reg == S_RETRY) && (short_cnt_reg == RETEST_T);
            pulldown_enable     <= olst_done & disabled_now;
        end
    end

endmodule
`default_nettype wire

// ==== sim/hbfs_line_partner.sv ====
// Host and peer drivers sharing the pulled-up open-drain enable/fault line.
`timescale 1ns/1ps
`default_nettype none
module hbfs_line_partner (
    // Clock.
    input  wire logic core_clk,
    // Device drive and host shutdown command.
    input  wire logic dev_oe_n,
    input  wire logic dev_out,
    input  wire logic pull_cmd,
    // Resolved line level.
    output wire logic line_level
);
    logic pull_reg;
    always_ff @(posedge core_clk) pull_reg <= pull_cmd;
    assign line_level = ((!dev_oe_n && !dev_out) || pull_reg) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ==== sim/hbfs_supervisor_sva.sv ====
// Concurrent checks on the ports of the bridge fault supervisor.
`timescale 1ns/1ps
`default_nettype none
module hbfs_checker #(
    parameter UV_FILTER = 4,
    parameter MON_OFF   = 4
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Bus handshake.
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Supply indications.
    input wire logic por_active,
    input wire logic por_below_threshold,
    input wire logic supply_undervoltage,
    input wire logic logic_undervoltage,
    input wire logic logic_overvoltage,
    // Line and bridge.
    input wire logic enable_fault_line_in,
    input wire logic enable_fault_line_oe_n,
    input wire logic bridge_enable,
    input wire logic pulldown_enable,
    input wire logic retry_drivers_on
);
    logic [7:0] uv_cnt;
    logic [7:0] mon_cnt;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Count consecutive cycles of supply undervoltage and of either logic supply fault.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            uv_cnt  <= 8'h00;
            mon_cnt <= 8'h00;
        end else begin
            uv_cnt  <= supply_undervoltage ? uv_cnt + {7'h00, uv_cnt != 8'hFF} : 8'h00;
            mon_cnt <= (logic_undervoltage || logic_overvoltage) ? mon_cnt + {7'h00, mon_cnt != 8'hFF} : 8'h00;
        end
    end
    ////////////////////////////////////////////////////////////////
    sequence no_pulldown; !pulldown_enable [*4]; endsequence
    sequence line_held; !enable_fault_line_oe_n [*4]; endsequence
    bus_answer_a: assert property (
        (avs_read || avs_write) && avs_waitrequest && !por_below_threshold |=> !avs_waitrequest)
        else $error("access not answered");
    answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than a cycle");
    line_tristates_a: assert property (!enable_fault_line_in |=> !bridge_enable)
        else $error("bridge on while line low");
    uv_filter_a: assert property ((uv_cnt > UV_FILTER + 3) |-> !bridge_enable)
        else $error("undervoltage did not tristate");
    mon_off_a: assert property (
        (mon_cnt > MON_OFF + 3) && !por_below_threshold |-> !enable_fault_line_oe_n)
        else $error("monitor fault did not pull line");
    mon_on_a: assert property (
        $fell(logic_undervoltage || logic_overvoltage) && !enable_fault_line_oe_n |=> line_held)
        else $error("line released before on filter");
    por_hold_a: assert property (
        por_active && !por_below_threshold |=> !enable_fault_line_oe_n && !bridge_enable)
        else $error("reset did not hold line and tristate");
    por_release_a: assert property (por_active && por_below_threshold |=> enable_fault_line_oe_n)
        else $error("line not released below threshold");
    ol_delay_a: assert property ($fell(bridge_enable) |=> no_pulldown)
        else $error("pull-down applied before start delay");
    retry_pulse_a: assert property (retry_drivers_on |=> !retry_drivers_on)
        else $error("retry pulse too long");
endmodule
bind hbfs_supervisor hbfs_checker #(.UV_FILTER(UV_FILTER), .MON_OFF(MON_OFF)) u_chk (
    .core_clk, .rst_n, .avs_read, .avs_write, .avs_waitrequest, .por_active, .por_below_threshold,
    .supply_undervoltage, .logic_undervoltage, .logic_overvoltage, .enable_fault_line_in,
    .enable_fault_line_oe_n, .bridge_enable, .pulldown_enable, .retry_drivers_on);
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the bridge fault supervisor.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam UVF = 4, MOFF = 4, MON = 8, PORC = 20, RTC = 4, OLS = 6, OLT = 4;
    logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest, por_active, por_below_threshold;
    logic supply_undervoltage, logic_undervoltage, logic_overvoltage, test_upper_exceeded;
    logic test_lower_exceeded, short_to_battery, short_to_ground, disable_input, pull;
    logic enable_fault_line_out, enable_fault_line_oe_n, bridge_enable, opposite_driver_off;
    logic retry_drivers_on, pulldown_enable, high_side_off, output_below_ground, pullup_single, pullup_double;
    wire logic enable_fault_line_in;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [7:0]  rv;
    int          err_total, tests_run;
    hbfs_supervisor #(.RETEST_CYC(RTC), .SCL_CYC(RTC), .OL_START(OLS), .OL_SETTLE(OLT), .OL_FILTER(OLT),
        .UV_FILTER(UVF), .MON_OFF(MOFF), .MON_ON(MON), .POR_CYC(PORC)) dut (
        .core_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
        .avs_readdata, .avs_waitrequest, .por_active, .por_below_threshold, .supply_undervoltage,
        .logic_undervoltage, .logic_overvoltage, .test_upper_exceeded, .test_lower_exceeded,
        .short_to_battery, .short_to_ground, .high_side_off, .output_below_ground,
        .pullup_single, .pullup_double, .disable_input, .enable_fault_line_in,
        .enable_fault_line_out, .enable_fault_line_oe_n, .bridge_enable, .opposite_driver_off,
        .retry_drivers_on, .pulldown_enable);
    hbfs_line_partner peer (.core_clk, .dev_oe_n(enable_fault_line_oe_n), .dev_out(enable_fault_line_out),
        .pull_cmd(pull), .line_level(enable_fault_line_in));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        if (err_total == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest && n < 100);
        rv = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest) begin
            err_total++;
            $display("[ERR] %0t bus timeout", $time);
            report_and_stop;
        end
    endtask
    task automatic recover;
        disable_input <= 1'b1;
        cyc(3);
        disable_input <= 1'b0;
        cyc(MON + 4);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_regs;
        bus(1'b0, 4'h0, 8'h00);
        chk(rv, 8'h00);
        bus(1'b0, 4'h2, 8'h00);
        chk(rv, 8'h00);
        bus(1'b1, 4'h0, 8'h01);
        bus(1'b0, 4'h0, 8'h00);
        chk(rv, 8'h01);
        chk(bridge_enable, 8'h01);
    endtask
    task automatic t_line;
        pull <= 1'b1;
        cyc(4);
        chk(bridge_enable, 8'h00);
        pull <= 1'b0;
        cyc(4);
        chk(bridge_enable, 8'h01);
    endtask
    task automatic t_uv;
        supply_undervoltage <= 1'b1;
        cyc(2);
        chk(bridge_enable, 8'h01);
        cyc(UVF + 4);
        chk(bridge_enable, 8'h00);
        supply_undervoltage <= 1'b0;
        cyc(4);
    endtask
    task automatic t_ov(input logic latch);
        bus(1'b1, 4'h4, {7'h00, latch});
        logic_overvoltage <= 1'b1;
        cyc(MOFF + 4);
        chk(enable_fault_line_oe_n, 8'h00);
        bus(1'b0, 4'h4, 8'h00);
        chk(rv, {7'h04, latch});
        logic_overvoltage <= 1'b0;
        cyc(3);
        chk(enable_fault_line_oe_n, 8'h00);
        cyc(MON + 4);
        chk(enable_fault_line_oe_n, {7'h00, !latch});
        if (latch)
            recover;
        chk(enable_fault_line_oe_n, 8'h01);
        bus(1'b1, 4'h4, 8'h00);
    endtask
    task automatic t_short(input logic keep);
        int n;
        n = 0;
        if (keep)
            short_to_battery <= 1'b1;
        else
            short_to_ground <= 1'b1;
        while (!opposite_driver_off && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        short_to_ground <= 1'b0;
        cyc(16);
        short_to_battery <= 1'b0;
        bus(1'b0, 4'h8, 8'h00);
        chk(rv, keep ? 8'h01 : 8'h04);
        chk(enable_fault_line_oe_n, 8'h00);
        bus(1'b1, 4'h8, 8'hFF);
        bus(1'b0, 4'h8, 8'h00);
        chk(rv, 8'h00);
        chk(bridge_enable, 8'h00);
        recover;
        chk(bridge_enable, 8'h01);
    endtask
    task automatic t_test;
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, 4'h4, i ? 8'h04 : 8'h02);
            test_upper_exceeded <= (i == 0);
            test_lower_exceeded <= (i == 0);
            cyc(MOFF + 4);
            bus(1'b0, 4'h4, 8'h00);
            chk(rv, i ? 8'h0C : 8'h0A);
            test_upper_exceeded <= 1'b0;
            test_lower_exceeded <= 1'b1;
            bus(1'b1, 4'h4, 8'h00);
            cyc(MON + 4);
            bus(1'b0, 4'h4, 8'h00);
            chk(rv, 8'h00);
        end
    endtask
    task automatic t_ol;
        disable_input <= 1'b1;
        pullup_single <= 1'b1;
        pullup_double <= 1'b0;
        cyc(OLS + 2 * OLT + 6);
        chk(pulldown_enable, 8'h01);
        bus(1'b0, 4'h8, 8'h00);
        chk(rv, 8'h08);
        disable_input <= 1'b0;
        pullup_single <= 1'b0;
        pullup_double <= 1'b1;
        bus(1'b1, 4'h8, 8'h08);
        high_side_off <= 1'b1;
        cyc(OLT + 4);
        bus(1'b0, 4'h8, 8'h00);
        chk(rv, 8'h08);
        high_side_off <= 1'b0;
        bus(1'b1, 4'h8, 8'h08);
        cyc(4);
    endtask
    task automatic t_por;
        por_active <= 1'b1;
        cyc(3);
        chk(enable_fault_line_oe_n, 8'h00);
        chk(bridge_enable, 8'h00);
        bus(1'b0, 4'h0, 8'h00);
        chk(rv, 8'h00);
        por_below_threshold <= 1'b1;
        cyc(3);
        chk(enable_fault_line_oe_n, 8'h01);
        por_below_threshold <= 1'b0;
        por_active <= 1'b0;
        cyc(5);
        chk(enable_fault_line_oe_n, 8'h00);
        cyc(PORC + 4);
        chk(bridge_enable, 8'h01);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, avs_read, avs_write, por_active, por_below_threshold, supply_undervoltage} = '0;
        {logic_undervoltage, logic_overvoltage, test_upper_exceeded, short_to_battery} = '0;
        {short_to_ground, disable_input, pull, avs_address, avs_writedata} = '0;
        {high_side_off, output_below_ground, pullup_single} = '0;
        {test_lower_exceeded, pullup_double} = 2'b11;
        err_total = 0;
        tests_run = 0;
        cyc(10);
        rst_n <= 1'b1;
        cyc(PORC + 5);
        t_regs;
        t_line;
        t_uv;
        t_ov(1'b1);
        t_ov(1'b0);
        short_to_battery <= 1'b1;
        cyc(1);
        short_to_battery <= 1'b0;
        cyc(30);
        bus(1'b0, 4'h8, 8'h00);
        chk(rv, 8'h00);
        t_short(1'b1);
        t_short(1'b0);
        t_test;
        t_ol;
        t_por;
        report_and_stop;
    end
endmodule
`default_nettype wire
